// file: logic/sec_cfg_pkg.sv
// Summary of operation
// - Interrupt routing byte is read-write in both directions, resets to zero.
// - Interrupt pin byte reads 01h in forward mode, 00h in reverse mode.
// - Minimum grant byte bits 23:16 is read-only and reads zero.
// - Maximum latency byte bits 31:24 is read-only and reads zero.
// - Capability header returns identifier 07h and next pointer 90h.
// - Bit 16 reads one only in forward mode with wide strap high.
// - Bit 17 reads one in forward mode, zero in reverse mode.
// - Bit 18 sets on discarded split completion, forward mode only.
// - Bit 19 sets on unexpected split completion, reverse mode only.
// - Bit 20 sets when a split completion is cut for buffer full.
// - Bit 21 sets when a split request is delayed by commitment limit.
// - Bits 24:22 give secondary clock code in forward mode, zero reverse.
package sec_cfg_pkg;

  // Dword offsets in configuration space
  localparam logic [7:0] OFF_SEC_IRQ = 8'h7c;
  localparam logic [7:0] OFF_PCIX_CAP = 8'h80;

  // Byte fields of the interrupt dword
  localparam int ROUTING_LSB = 0;
  localparam int PIN_LSB = 8;
  localparam int BURST_LSB = 16;
  localparam int INTERVAL_LSB = 24;

  // Fixed values and reset values
  localparam logic [7:0] ROUTING_RST = 8'h00;
  localparam logic [7:0] PIN_FWD_VAL = 8'h01;
  localparam logic [7:0] PIN_REV_VAL = 8'h00;
  localparam logic [7:0] BURST_VAL = 8'h00;
  localparam logic [7:0] INTERVAL_VAL = 8'h00;
  localparam logic [7:0] CAP_ID_VAL = 8'h07;
  localparam logic [7:0] CAP_LINK_VAL = 8'h90;

  // Capability dword fields
  localparam int CAP_ID_LSB = 0;
  localparam int CAP_LINK_LSB = 8;
  localparam int WIDE_BIT = 16;
  localparam int FAST_BIT = 17;
  localparam int FLAG_LSB = 18;
  localparam int FLAG_COUNT = 4;
  localparam int CLK_LSB = 22;
  localparam int CLK_W = 3;

  // Flag indices inside the flag vector (bits 18..21)
  localparam int FLG_DISCARD = 0;
  localparam int FLG_UNEXPECTED = 1;
  localparam int FLG_OVERRUN = 2;
  localparam int FLG_DELAYED = 3;
  localparam logic [FLAG_COUNT-1:0] FLAG_RST = 4'h0;

  // Secondary clock codes
  localparam logic [CLK_W-1:0] CLK_CONV = 3'h0;
  localparam logic [CLK_W-1:0] CLK_66 = 3'h1;
  localparam logic [CLK_W-1:0] CLK_133 = 3'h2;

  // Strap synchroniser width: direction, wide strap, clock code
  localparam int STRAP_W = 5;

  // Bridge direction
  typedef enum logic {
    DIR_FORWARD = 1'b0,
    DIR_REVERSE = 1'b1
  } bridge_dir_t;

  // Strap capture sequence after reset release; the synchroniser is
  // cleared by reset, so two edges pass before it shows the pins
  typedef enum logic [1:0] {
    CAP_WAIT = 2'b00,
    CAP_FILL = 2'b01,
    CAP_SETTLE = 2'b10,
    CAP_DONE = 2'b11
  } capture_st_t;

  // Dword decode shared by read and write paths
  function automatic logic hits_dword(input logic [7:0] addr,
                                      input logic [7:0] off);
    hits_dword = (addr[7:2] == off[7:2]);
  endfunction

endpackage

// file: logic/strap_sync.sv
`timescale 1ns/1ps
module strap_sync
  import sec_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Asynchronous pin levels and their synchronised copies
  input wire logic [STRAP_W-1:0] pin_in,
  output logic [STRAP_W-1:0] pin_sync
);

  logic [STRAP_W-1:0] meta_reg;

  // Two stages; only the second stage is seen by any logic
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      pin_sync <= '0;
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end

endmodule

// file: logic/bridge_secondary_cfg_status.sv
`timescale 1ns/1ps
module bridge_secondary_cfg_status
  import sec_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Configuration access port
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rdata_valid,
  // Straps and secondary clock detect pins
  input wire logic reverse_mode_strap,
  input wire logic wide_bus_strap,
  input wire logic [CLK_W-1:0] sec_clk_code,
  // Split transaction events from the datapath
  input wire logic split_discard_evt,
  input wire logic unexpected_cpl_evt,
  input wire logic cpl_overrun_evt,
  input wire logic split_delayed_evt,
  // State seen by the rest of the bridge
  output logic [7:0] irq_routing,
  output logic bridge_reverse,
  output logic mode_valid
);

  logic [STRAP_W-1:0] strap_sync_q;
  logic rev_sync;
  logic wide_sync;
  logic [CLK_W-1:0] clk_sync;
  capture_st_t cap_reg;
  capture_st_t cap_next;
  bridge_dir_t dir_reg;
  logic fwd;
  logic [7:0] routing_reg;
  logic [FLAG_COUNT-1:0] flag_reg;
  logic [FLAG_COUNT-1:0] flag_set;
  logic [FLAG_COUNT-1:0] flag_clr;
  logic [CLK_W-1:0] clk_code_reg;
  logic wide_bit;
  logic fast_bit;
  logic [7:0] pin_code;
  logic [31:0] irq_word;
  logic [31:0] cap_word;
  logic [31:0] rdata_next;
  logic wr_irq;
  logic wr_cap;

  // Strap pins arrive unsynchronised to the bridge clock
  strap_sync u_strap_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin_in({sec_clk_code, wide_bus_strap, reverse_mode_strap}),
    .pin_sync(strap_sync_q)
  );

  assign rev_sync = strap_sync_q[0];
  assign wide_sync = strap_sync_q[1];
  assign clk_sync = strap_sync_q[4:2];

  // Capture sequence: wait for the synchroniser to fill, then latch once
  always_comb begin
    case (cap_reg)
      CAP_WAIT: cap_next = CAP_FILL;
      CAP_FILL: cap_next = CAP_SETTLE;
      CAP_SETTLE: cap_next = CAP_DONE;
      CAP_DONE: cap_next = CAP_DONE;
      default: cap_next = CAP_DONE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cap_reg <= CAP_WAIT;
    end else begin
      cap_reg <= cap_next;
    end
  end

  // Direction is frozen once captured so a moving reverse strap never shifts read values mid-run
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dir_reg <= DIR_FORWARD;
    end else if (cap_reg == CAP_SETTLE) begin
      dir_reg <= rev_sync ? DIR_REVERSE : DIR_FORWARD;
    end
  end

  assign fwd = (dir_reg == DIR_FORWARD);
  assign mode_valid = (cap_reg == CAP_DONE);
  assign bridge_reverse = (dir_reg == DIR_REVERSE);

  // Write strobes per dword
  assign wr_irq = cfg_wr && hits_dword(cfg_addr, OFF_SEC_IRQ);
  assign wr_cap = cfg_wr && hits_dword(cfg_addr, OFF_PCIX_CAP);

  // Interrupt routing byte, filled by initialisation software
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      routing_reg <= ROUTING_RST;
    end else if (wr_irq && cfg_be[0]) begin
      routing_reg <= cfg_wdata[ROUTING_LSB +: 8];
    end
  end

  assign irq_routing = routing_reg;

  // Set events; discard and unexpected are gated by the direction that owns them.
  // Before capture the direction still reads forward, so the discard
  // flag also waits for mode_valid or a reverse bridge could set it.
  assign flag_set[FLG_DISCARD] =
    split_discard_evt && fwd && mode_valid;
  assign flag_set[FLG_UNEXPECTED] = unexpected_cpl_evt && !fwd;
  assign flag_set[FLG_OVERRUN] = cpl_overrun_evt;
  assign flag_set[FLG_DELAYED] = split_delayed_evt;

  // Flags all sit in byte lane 2 of the capability dword
  assign flag_clr = (wr_cap && cfg_be[2]) ?
    cfg_wdata[FLAG_LSB +: FLAG_COUNT] : '0;

  // Sticky flags; the set term is tested first so a racing event survives
  for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        flag_reg[i] <= FLAG_RST[i];
      end else if (flag_set[i]) begin
        flag_reg[i] <= 1'b1;
      end else if (flag_clr[i]) begin
        flag_reg[i] <= 1'b0;
      end
    end
  end

  // Secondary clock code follows the detect pins only in forward mode
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_code_reg <= CLK_CONV;
    end else if (fwd && mode_valid) begin
      clk_code_reg <= clk_sync;
    end else begin
      clk_code_reg <= CLK_CONV;
    end
  end

  // Capability bits derived from direction and strap
  assign wide_bit = fwd && wide_sync;
  assign fast_bit = fwd;
  assign pin_code = fwd ? PIN_FWD_VAL : PIN_REV_VAL;

  // Interrupt dword image
  always_comb begin
    irq_word = '0;
    irq_word[ROUTING_LSB +: 8] = routing_reg;
    irq_word[PIN_LSB +: 8] = pin_code;
    irq_word[BURST_LSB +: 8] = BURST_VAL;
    irq_word[INTERVAL_LSB +: 8] = INTERVAL_VAL;
  end

  // Capability dword image; bits 31:25 stay zero
  always_comb begin
    cap_word = '0;
    cap_word[CAP_ID_LSB +: 8] = CAP_ID_VAL;
    cap_word[CAP_LINK_LSB +: 8] = CAP_LINK_VAL;
    cap_word[WIDE_BIT] = wide_bit;
    cap_word[FAST_BIT] = fast_bit;
    cap_word[FLAG_LSB +: FLAG_COUNT] = flag_reg;
    cap_word[CLK_LSB +: CLK_W] = clk_code_reg;
  end

  // Read mux; any other dword reads as zero
  always_comb begin
    if (hits_dword(cfg_addr, OFF_SEC_IRQ)) begin
      rdata_next = irq_word;
    end else if (hits_dword(cfg_addr, OFF_PCIX_CAP)) begin
      rdata_next = cap_word;
    end else begin
      rdata_next = '0;
    end
  end

  // Read data is held until the next read; valid is cfg_rd delayed by one cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata <= '0;
    end else if (cfg_rd) begin
      cfg_rdata <= rdata_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata_valid <= 1'b0;
    end else begin
      cfg_rdata_valid <= cfg_rd;
    end
  end

  // Checks on the register behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  chk_routing_write: assert property (
    wr_irq && cfg_be[0] |=> routing_reg == $past(cfg_wdata[7:0]))
    else $error("routing byte did not take the write");

  chk_pin_code: assert property (
    cfg_rd && hits_dword(cfg_addr, OFF_SEC_IRQ)
    |=> cfg_rdata_valid && cfg_rdata[15:8] ==
        ($past(bridge_reverse) ? 8'h00 : 8'h01))
    else $error("interrupt pin code wrong for direction");

  chk_burst_zero: assert property (
    cfg_rd && hits_dword(cfg_addr, OFF_SEC_IRQ)
    |=> cfg_rdata[23:16] == 8'h00)
    else $error("minimum grant byte not zero");

  chk_interval_zero: assert property (
    cfg_rd && hits_dword(cfg_addr, OFF_SEC_IRQ)
    |=> cfg_rdata[31:24] == 8'h00)
    else $error("maximum latency byte not zero");

  chk_cap_header: assert property (
    cfg_rd && hits_dword(cfg_addr, OFF_PCIX_CAP)
    |=> cfg_rdata[15:0] == 16'h9007 && cfg_rdata[31:25] == 7'h00)
    else $error("capability header wrong");

  chk_wide_bit: assert property (
    cfg_rd && hits_dword(cfg_addr, OFF_PCIX_CAP)
    |=> cfg_rdata[16] == ($past(wide_sync) && !$past(bridge_reverse)))
    else $error("64-bit bit does not follow strap and direction");

  chk_fast_bit: assert property (
    cfg_rd && hits_dword(cfg_addr, OFF_PCIX_CAP)
    |=> cfg_rdata[17] == !$past(bridge_reverse))
    else $error("133MHz bit wrong for direction");

  chk_discard_set: assert property (
    split_discard_evt && fwd && mode_valid
    |=> flag_reg[FLG_DISCARD] ##1
        (flag_reg[FLG_DISCARD] || $past(flag_clr[FLG_DISCARD])))
    else $error("discard flag not set and held");

  chk_discard_rev: assert property (
    bridge_reverse && mode_valid |=> !flag_reg[FLG_DISCARD])
    else $error("discard flag set in reverse mode");

  chk_unexp_fwd: assert property (
    !bridge_reverse && mode_valid |=> !flag_reg[FLG_UNEXPECTED])
    else $error("unexpected completion flag set in forward mode");

  chk_unexp_set: assert property (
    unexpected_cpl_evt && bridge_reverse |=> flag_reg[FLG_UNEXPECTED])
    else $error("unexpected completion flag not set");

  chk_overrun_set: assert property (
    cpl_overrun_evt |=> flag_reg[FLG_OVERRUN])
    else $error("overrun flag not set");

  chk_delayed_set: assert property (
    split_delayed_evt |=> flag_reg[FLG_DELAYED])
    else $error("delayed request flag not set");

  chk_clk_code: assert property (
    mode_valid |=> (bridge_reverse ? clk_code_reg == 3'h0
                                   : clk_code_reg == $past(clk_sync)))
    else $error("clock code wrong for direction");

  chk_w1c_clear: assert property (
    wr_cap && cfg_be[2] && cfg_wdata[20] && !cpl_overrun_evt
    |=> !flag_reg[FLG_OVERRUN])
    else $error("write one did not clear overrun flag");

  chk_flag_hold: assert property (
    flag_reg[FLG_DELAYED] && !(wr_cap && cfg_be[2] && cfg_wdata[21])
    |=> flag_reg[FLG_DELAYED])
    else $error("delayed flag dropped without a clearing write");

  chk_routing_hold: assert property (
    !(wr_irq && cfg_be[0]) |=> $stable(routing_reg))
    else $error("routing byte changed without a write");

  chk_set_wins: assert property (
    split_delayed_evt && wr_cap && cfg_be[2] && cfg_wdata[21]
    |=> flag_reg[FLG_DELAYED])
    else $error("clearing write beat a same-cycle set event");

  chk_unexp_clear: assert property (
    wr_cap && cfg_be[2] && cfg_wdata[19] && !unexpected_cpl_evt
    |=> !flag_reg[FLG_UNEXPECTED])
    else $error("write one did not clear unexpected flag");

  chk_lane_gate: assert property (
    flag_reg[FLG_OVERRUN] && !(wr_cap && cfg_be[2])
    |=> flag_reg[FLG_OVERRUN])
    else $error("overrun flag cleared without byte lane 2");

  chk_mode_stable: assert property (
    mode_valid |=> mode_valid && $stable(bridge_reverse))
    else $error("bridge direction changed after capture");

  chk_mode_latency: assert property (
    rstn && !mode_valid |-> ##[1:3] mode_valid)
    else $error("direction not captured within three cycles");

endmodule

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
  import sec_cfg_pkg::*;
  logic ref_clk, rstn, cfg_wr, cfg_rd, rev_strap, wide_strap;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be, evt;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [2:0] clk_pins;
  logic cfg_rdata_valid, bridge_reverse, mode_valid;
  logic [7:0] irq_routing;
  int errors, n_checks;
  // Reference model state
  logic [7:0] m_route;
  logic [3:0] m_flg;
  logic m_rev, m_wide;
  logic [2:0] m_code;

  bridge_secondary_cfg_status u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rdata_valid(cfg_rdata_valid),
    .reverse_mode_strap(rev_strap), .wide_bus_strap(wide_strap),
    .sec_clk_code(clk_pins), .split_discard_evt(evt[0]),
    .unexpected_cpl_evt(evt[1]), .cpl_overrun_evt(evt[2]),
    .split_delayed_evt(evt[3]), .irq_routing(irq_routing),
    .bridge_reverse(bridge_reverse), .mode_valid(mode_valid));

  // 20 MHz bridge clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected dword, built from the field layout of each register
  function automatic logic [31:0] exp_word(input logic [7:0] a);
    if (a[7:2] == 6'h1f)
      return {8'h00, 8'h00, (m_rev ? 8'h00 : 8'h01), m_route};
    if (a[7:2] == 6'h20)
      return {7'h00, (m_rev ? 3'h0 : m_code), m_flg, ~m_rev,
              ~m_rev & m_wide, 8'h90, 8'h07};
    return 32'h0;
  endfunction

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    @(negedge ref_clk);
    chk("rdata_valid", 32'h1, {31'h0, cfg_rdata_valid});
    chk("rdata", exp_word(a), cfg_rdata);
  endtask

  // One access cycle: optional event pulse and optional write together
  task automatic cyc(input logic [3:0] e, input logic w, input logic [7:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    @(posedge ref_clk);
    evt <= e;
    cfg_wr <= w;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge ref_clk);
    evt <= 4'h0;
    cfg_wr <= 1'b0;
    // Clear first so that a same-cycle set event wins
    if (w && a[7:2] == 6'h1f && be[0]) m_route = d[7:0];
    if (w && a[7:2] == 6'h20 && be[2]) m_flg &= ~d[21:18];
    m_flg |= e & (m_rev ? 4'b1110 : 4'b1101);
  endtask

  task automatic chk_all();
    rd(8'h7c);
    rd(8'h80);
    chk("irq_routing", {24'h0, m_route}, {24'h0, irq_routing});
    chk("bridge_reverse", {31'h0, m_rev}, {31'h0, bridge_reverse});
    chk("mode_valid", 32'h1, {31'h0, mode_valid});
  endtask

  task automatic do_reset(input logic r, input logic w, input logic [2:0] c);
    @(posedge ref_clk);
    rstn <= 1'b0;
    rev_strap <= r;
    wide_strap <= w;
    clk_pins <= c;
    m_rev = r;
    m_wide = w;
    m_code = c;
    m_route = 8'h00;
    m_flg = 4'h0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 20 && mode_valid !== 1'b1; i++) @(posedge ref_clk);
    // Strap synchronisers and the clock code lag a few edges
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic flag_tests(input string nm);
    // Random event traffic with random clears
    for (int i = 0; i < 24; i++) begin
      cyc($urandom() & 4'hf, ($urandom() % 3) == 0, 8'h80, 4'h4,
          $urandom());
      if (i % 6 == 5) rd(8'h80);
    end
    // Set and clear in one cycle: the set must survive
    cyc(4'hf, 1'b1, 8'h80, 4'h4, 32'h003c_0000);
    rd(8'h80);
    // Clear without byte lane 2 is ignored, then a real clear
    cyc(4'h0, 1'b1, 8'h80, 4'hb, 32'hffff_ffff);
    rd(8'h80);
    cyc(4'h0, 1'b1, 8'h80, 4'h4, 32'h003c_0000);
    rd(8'h80);
    $display("test %s done", nm);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog: the full run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    rstn = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    evt = 4'h0;
    rev_strap = 1'b0;
    wide_strap = 1'b1;
    clk_pins = 3'h2;
    errors = 0;
    n_checks = 0;
    void'($urandom(32'hcf32));
    // Forward bridge, wide bus, fast secondary clock
    do_reset(1'b0, 1'b1, 3'h2);
    chk_all();
    $display("test fwd_reset done");
    // Routing byte: only lane 0 writes, other bytes stay fixed
    for (int i = 0; i < 4; i++) begin
      cyc(4'h0, 1'b1, 8'h7c, 4'hf, $urandom());
      cyc(4'h0, 1'b1, 8'h7c, 4'he, $urandom());
      chk_all();
    end
    rd(8'h84);
    rd(8'h00);
    $display("test routing done");
    flag_tests("fwd_flags");
    // Live wide strap and every clock code; direction must not move
    for (int c = 0; c < 3; c++) begin
      @(posedge ref_clk);
      rev_strap <= 1'b1;
      wide_strap <= c[0];
      clk_pins <= c[2:0];
      m_wide = c[0];
      m_code = c[2:0];
      repeat (6) @(posedge ref_clk);
      chk_all();
    end
    $display("test straps done");
    // Reverse bridge
    do_reset(1'b1, 1'b1, 3'h2);
    chk_all();
    cyc(4'h0, 1'b1, 8'h7c, 4'h1, $urandom());
    chk_all();
    flag_tests("rev_flags");
    tally_and_finish();
  end
endmodule
